// file: core/rmps_defines.vh
// Register offsets, field positions, reset values and protocol encodings
`ifndef RMPS_DEFINES_VH
`define RMPS_DEFINES_VH

// Register offsets on the host register port
`define RMPS_ADDR_W          5
`define RMPS_OFS_CHIP_MODE   5'h00
`define RMPS_OFS_PROTO_SEL   5'h01

// Reset values
`define RMPS_RST_CHIP_MODE   8'h01
`define RMPS_RST_PROTO_SEL   8'h02
`define RMPS_RDATA_UNMAPPED  8'h00

// Chip mode control fields
`define RMPS_CM_STANDBY      7
`define RMPS_CM_DIRECT       6
`define RMPS_CM_FIELD_EN     5
`define RMPS_CM_HALF_PWR     4
`define RMPS_CM_AUX_IN       3
`define RMPS_CM_RESERVED     2
`define RMPS_CM_FORCE_RX     1
`define RMPS_CM_SUPPLY       0

// Protocol select fields
`define RMPS_PS_NO_CRC       7
`define RMPS_PS_DIR_VAR      6
`define RMPS_PS_READER_MODE  5
`define RMPS_PS_CODE_HI      4
`define RMPS_PS_CODE_LO      0

// Protocol family encodings
`define RMPS_FAM_W           3
`define RMPS_FAM_VIC_SINGLE  3'h0
`define RMPS_FAM_VIC_DOUBLE  3'h1
`define RMPS_FAM_PROX_A      3'h2
`define RMPS_FAM_PROX_B      3'h3
`define RMPS_FAM_PROPRIETARY 3'h4
`define RMPS_FAM_RESERVED    3'h7

// Protocol code groups (upper code bits) and two full 5-bit codes
`define RMPS_GRP_VIC_SINGLE  3'h0
`define RMPS_GRP_VIC_DOUBLE  3'h1
`define RMPS_GRP_PROX_A      3'h2
`define RMPS_GRP_PROX_B      3'h3
`define RMPS_CODE_PROP_LOW   5'h1a
`define RMPS_CODE_PROP_HIGH  5'h1b

// Receive rate select encodings for proprietary protocol
`define RMPS_RATE_212        2'h1
`define RMPS_RATE_424        2'h2

`endif

// file: core/rmps_proto_decode.v
// Protocol code decoder: family, receive rate and coding from a 5-bit code
`timescale 1ns/1ps
`include "rmps_defines.vh"

module rmps_proto_decode (
	input  wire [4:0] i_code,
	output reg  [2:0] o_family,
	output reg  [1:0] o_rx_rate,
	output reg        o_coding_256,
	output reg        o_reserved
);

	// Upper three bits pick the group, lower two pick rate or coding
	wire [2:0] grp;
	assign grp = i_code[4:2];

	// Pure decode; the top registers the results
	always @* begin
		o_family     = `RMPS_FAM_RESERVED;
		o_rx_rate    = 2'h0;
		o_coding_256 = 1'b0;
		o_reserved   = 1'b0;
		if (grp == `RMPS_GRP_VIC_SINGLE) begin
			// Bit 1 high rate, bit 0 one-of-256
			o_family     = `RMPS_FAM_VIC_SINGLE;
			o_rx_rate    = {1'b0, i_code[1]};
			o_coding_256 = i_code[0];
		end else if (grp == `RMPS_GRP_VIC_DOUBLE) begin
			// Double subcarrier, same bit meaning
			o_family     = `RMPS_FAM_VIC_DOUBLE;
			o_rx_rate    = {1'b0, i_code[1]};
			o_coding_256 = i_code[0];
		end else if (grp == `RMPS_GRP_PROX_A) begin
			// 106/212/424/848 ascending
			o_family  = `RMPS_FAM_PROX_A;
			o_rx_rate = i_code[1:0];
		end else if (grp == `RMPS_GRP_PROX_B) begin
			// 106/212/424/848 ascending
			o_family  = `RMPS_FAM_PROX_B;
			o_rx_rate = i_code[1:0];
		end else if (i_code == `RMPS_CODE_PROP_LOW) begin
			// Proprietary protocol at 212 kbps
			o_family  = `RMPS_FAM_PROPRIETARY;
			o_rx_rate = `RMPS_RATE_212;
		end else if (i_code == `RMPS_CODE_PROP_HIGH) begin
			// Proprietary protocol at 424 kbps
			o_family  = `RMPS_FAM_PROPRIETARY;
			o_rx_rate = `RMPS_RATE_424;
		end else begin
			// Unlisted code: flagged, no protocol behaviour
			o_reserved = 1'b1;
		end
	end

endmodule

// file: core/rmps_top.v
// Reader mode and protocol select register bank with decoded controls
`timescale 1ns/1ps
`include "rmps_defines.vh"

module rmps_top #(
	parameter ADDR_W = `RMPS_ADDR_W
) (
	input  wire              I_CLK,
	input  wire              I_RST,
	input  wire              I_CHIP_EN,
	input  wire              I_WR_EN,
	input  wire              I_RD_EN,
	input  wire [ADDR_W-1:0] I_ADDR,
	input  wire [7:0]        I_WDATA,
	output reg  [7:0]        O_RDATA,
	output reg               O_RDATA_VALID,
	output reg               O_STANDBY,
	output reg               O_DIRECT_ACTIVE,
	output reg               O_DIRECT_MODE1,
	output reg               O_TX_ENABLE,
	output reg               O_RX_ENABLE,
	output reg               O_TX_OSC_ENABLE,
	output reg               O_TX_HALF_POWER,
	output reg               O_AUX_INPUT_SEL,
	output reg               O_SUPPLY_5V,
	output reg               O_NO_RX_CRC,
	output reg [2:0]         O_PROTO_FAMILY,
	output reg [1:0]         O_RX_RATE_SEL,
	output reg               O_CODING_256,
	output reg               O_DOUBLE_SUBCARRIER,
	output reg               O_PROTO_RESERVED,
	output reg               O_OPTION_RELOAD
);

	// Stored register contents
	reg  [7:0] chip_mode_control;
	reg  [7:0] protocol_select_reg;

	// Write strobes per register
	wire       wr_chip_mode;
	wire       wr_proto_sel;
	wire       rst_any;

	// Next values seen by the output flops
	reg  [7:0] next_chip_mode;
	reg  [7:0] next_proto_sel;
	reg  [7:0] next_rdata;

	// Decoder results for the next protocol code
	wire [2:0] dec_family;
	wire [1:0] dec_rx_rate;
	wire       dec_coding_256;
	wire       dec_reserved;

	// Reset image of chip mode; only the standby output reset value is taken from it
	localparam [7:0] rst_chip_mode = `RMPS_RST_CHIP_MODE;

	// Chip enable low acts as a reset of both registers
	assign rst_any = I_RST | ~I_CHIP_EN;

	// Address decode for writes
	assign wr_chip_mode = I_WR_EN & (I_ADDR == `RMPS_OFS_CHIP_MODE);
	assign wr_proto_sel = I_WR_EN & (I_ADDR == `RMPS_OFS_PROTO_SEL);

	// Next register contents; reserved bit 2 is never stored
	always @* begin
		next_chip_mode = chip_mode_control;
		next_proto_sel = protocol_select_reg;
		if (wr_chip_mode) begin
			next_chip_mode = I_WDATA;
			next_chip_mode[`RMPS_CM_RESERVED] = 1'b0;
		end
		if (wr_proto_sel) begin
			// Bit 5 kept as written; host owns keeping it zero
			next_proto_sel = I_WDATA;
		end
	end

	// Decode the code that will be stored, so outputs track in one cycle
	rmps_proto_decode u_decode (
		.i_code       (next_proto_sel[`RMPS_PS_CODE_HI:`RMPS_PS_CODE_LO]),
		.o_family     (dec_family),
		.o_rx_rate    (dec_rx_rate),
		.o_coding_256 (dec_coding_256),
		.o_reserved   (dec_reserved)
	);

	// Register storage with reset values
	always @(posedge I_CLK) begin
		if (rst_any) begin
			chip_mode_control   <= `RMPS_RST_CHIP_MODE;
			protocol_select_reg <= `RMPS_RST_PROTO_SEL;
		end else begin
			chip_mode_control   <= next_chip_mode;
			protocol_select_reg <= next_proto_sel;
		end
	end

	// Read mux; unmapped addresses read as zero
	always @* begin
		if (I_ADDR == `RMPS_OFS_CHIP_MODE) begin
			next_rdata = chip_mode_control;
		end else if (I_ADDR == `RMPS_OFS_PROTO_SEL) begin
			next_rdata = protocol_select_reg;
		end else begin
			next_rdata = `RMPS_RDATA_UNMAPPED;
		end
	end

	// Read answer one cycle after the strobe, held until next read
	always @(posedge I_CLK) begin
		if (rst_any) begin
			O_RDATA       <= `RMPS_RDATA_UNMAPPED;
			O_RDATA_VALID <= 1'b0;
		end else begin
			O_RDATA_VALID <= I_RD_EN;
			if (I_RD_EN) begin
				O_RDATA <= next_rdata;
			end
		end
	end

	// Chip mode controls, driven from the next value for equal latency
	always @(posedge I_CLK) begin
		if (rst_any) begin
			O_STANDBY       <= rst_chip_mode[`RMPS_CM_STANDBY];
			O_DIRECT_ACTIVE <= 1'b0;
			O_TX_ENABLE     <= 1'b0;
			O_RX_ENABLE     <= 1'b0;
			O_TX_OSC_ENABLE <= 1'b0;
			O_TX_HALF_POWER <= 1'b0;
			O_AUX_INPUT_SEL <= 1'b0;
			O_SUPPLY_5V     <= 1'b1;
		end else begin
			O_STANDBY       <= next_chip_mode[`RMPS_CM_STANDBY];
			O_DIRECT_ACTIVE <= next_chip_mode[`RMPS_CM_DIRECT];
			// Transmitter follows the field bit only
			O_TX_ENABLE     <= next_chip_mode[`RMPS_CM_FIELD_EN];
			// Forced receive overrides the field bit
			O_RX_ENABLE     <= next_chip_mode[`RMPS_CM_FORCE_RX] |
			                   next_chip_mode[`RMPS_CM_FIELD_EN];
			O_TX_OSC_ENABLE <= next_chip_mode[`RMPS_CM_FORCE_RX] |
			                   next_chip_mode[`RMPS_CM_FIELD_EN];
			O_TX_HALF_POWER <= next_chip_mode[`RMPS_CM_HALF_PWR];
			O_AUX_INPUT_SEL <= next_chip_mode[`RMPS_CM_AUX_IN];
			O_SUPPLY_5V     <= next_chip_mode[`RMPS_CM_SUPPLY];
		end
	end

	// Direct mode 1 only when direct access set with variant bit high
	always @(posedge I_CLK) begin
		if (rst_any) begin
			O_DIRECT_MODE1 <= 1'b0;
		end else begin
			// Variant is read live; host orders the writes
			O_DIRECT_MODE1 <= next_chip_mode[`RMPS_CM_DIRECT] &
			                  next_proto_sel[`RMPS_PS_DIR_VAR];
		end
	end

	// Protocol controls; reset state matches code 0x02
	always @(posedge I_CLK) begin
		if (rst_any) begin
			O_NO_RX_CRC         <= 1'b0;
			O_PROTO_FAMILY      <= `RMPS_FAM_VIC_SINGLE;
			O_RX_RATE_SEL       <= 2'h1;
			O_CODING_256        <= 1'b0;
			O_DOUBLE_SUBCARRIER <= 1'b0;
			O_PROTO_RESERVED    <= 1'b0;
		end else begin
			O_NO_RX_CRC         <= next_proto_sel[`RMPS_PS_NO_CRC];
			O_PROTO_FAMILY      <= dec_family;
			// Receive rate only; transmit rate lives elsewhere
			O_RX_RATE_SEL       <= dec_rx_rate;
			O_CODING_256        <= dec_coding_256;
			O_DOUBLE_SUBCARRIER <= (dec_family == `RMPS_FAM_VIC_DOUBLE);
			O_PROTO_RESERVED    <= dec_reserved;
		end
	end

	// Reload pulse on every protocol write, even the same code
	always @(posedge I_CLK) begin
		if (rst_any) begin
			O_OPTION_RELOAD <= 1'b0;
		end else begin
			O_OPTION_RELOAD <= wr_proto_sel;
		end
	end

endmodule

// file: testbench/rmps_host.sv
// Host model driving the strobed register port
`timescale 1ns/1ps
module rmps_host (
	input  logic       i_clk,
	input  logic [7:0] i_rdata,
	input  logic       i_rdata_valid,
	output logic       o_wr_en = 0,
	output logic       o_rd_en = 0,
	output logic [4:0] o_addr = 0,
	output logic [7:0] o_wdata = 0
);
	// Write; lines scrambled after release so stale data never passes
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge i_clk);
		#1;
		o_addr = a;
		o_wdata = d & (a == 1 ? 8'hdf : 8'hfb);
		o_wr_en = 1;
		@(posedge i_clk);
		#1;
		o_wr_en = 0;
		o_addr = ~a;
		o_wdata = ~o_wdata;
	endtask
	// Read; data taken one edge after the strobe
	task automatic rd(input logic [4:0] a, output logic [7:0] d,
		output logic v);
		@(posedge i_clk);
		#1;
		o_addr = a;
		o_rd_en = 1;
		@(posedge i_clk);
		#1;
		o_rd_en = 0;
		o_addr = ~a;
		d = i_rdata;
		v = i_rdata_valid;
	endtask
endmodule

// file: testbench/rmps_top_chk.sv
// Port checker for the mode and protocol register bank
`timescale 1ns/1ps
module rmps_top_chk #(parameter ADDR_W = 5) (
	input logic              I_CLK,
	input logic              I_RST,
	input logic              I_CHIP_EN,
	input logic              I_WR_EN,
	input logic [ADDR_W-1:0] I_ADDR,
	input logic [7:0]        I_WDATA,
	input logic              O_TX_ENABLE,
	input logic              O_RX_ENABLE,
	input logic              O_TX_HALF_POWER,
	input logic              O_AUX_INPUT_SEL,
	input logic              O_SUPPLY_5V,
	input logic              O_NO_RX_CRC,
	input logic              O_OPTION_RELOAD,
	input logic [1:0]        O_RX_RATE_SEL
);
	// Writes decoded per register
	wire cm_wr = I_WR_EN && I_ADDR == 0;
	wire ps_wr = I_WR_EN && I_ADDR == 1;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RST || !I_CHIP_EN);
	a_half_power: assert property (
		cm_wr |=> O_TX_HALF_POWER == $past(I_WDATA[4]))
		else $error("half power wrong");
	a_aux_input: assert property (
		cm_wr |=> O_AUX_INPUT_SEL == $past(I_WDATA[3]))
		else $error("input select wrong");
	a_rx_forced: assert property (
		cm_wr |=> O_RX_ENABLE == ($past(I_WDATA[1]) | $past(I_WDATA[5])))
		else $error("receiver enable wrong");
	a_supply_sel: assert property (
		cm_wr |=> O_SUPPLY_5V == $past(I_WDATA[0]))
		else $error("supply range wrong");
	a_reset_load: assert property (disable iff (1'b0)
		(I_RST || !I_CHIP_EN) |=> O_RX_RATE_SEL == 2'h1 && O_SUPPLY_5V)
		else $error("reset values wrong");
	a_no_crc: assert property (
		ps_wr |=> O_NO_RX_CRC == $past(I_WDATA[7]))
		else $error("crc select wrong");
	a_field_on: assert property (
		cm_wr |=> O_TX_ENABLE == $past(I_WDATA[5]))
		else $error("transmitter enable wrong");
	a_reload_pulse: assert property (
		1'b1 |=> O_OPTION_RELOAD == $past(ps_wr))
		else $error("option reload wrong");
endmodule
bind rmps_top rmps_top_chk #(.ADDR_W(ADDR_W)) u_chk (
	.I_CLK(I_CLK), .I_RST(I_RST), .I_CHIP_EN(I_CHIP_EN),
	.I_WR_EN(I_WR_EN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
	.O_TX_ENABLE(O_TX_ENABLE), .O_RX_ENABLE(O_RX_ENABLE),
	.O_TX_HALF_POWER(O_TX_HALF_POWER), .O_AUX_INPUT_SEL(O_AUX_INPUT_SEL),
	.O_SUPPLY_5V(O_SUPPLY_5V), .O_NO_RX_CRC(O_NO_RX_CRC),
	.O_OPTION_RELOAD(O_OPTION_RELOAD), .O_RX_RATE_SEL(O_RX_RATE_SEL));

// file: testbench/test_reader_mode_protocol_select.sv
// Self-checking bench for the mode and protocol register bank
`timescale 1ns/1ps
module test_reader_mode_protocol_select;
	logic       clk = 0;
	logic       rst = 1;
	logic       chip_en = 1;
	logic       wr_en, rd_en, rdv, rel, v, cod, dbl, res, dm1;
	logic       txe, rxe, osc, half, aux, s5, ncrc, stby, dact;
	logic [4:0] addr;
	logic [7:0] wdata, rdata, d, rv, ep;
	logic [2:0] fam;
	logic [1:0] rate;
	int         miscompares = 0;
	int         n_checks = 0;
	// 10 MHz clock
	always #50 clk = ~clk;
	rmps_host u_rmps_host (.i_clk(clk), .i_rdata(rdata),
		.i_rdata_valid(rdv), .o_wr_en(wr_en), .o_rd_en(rd_en),
		.o_addr(addr), .o_wdata(wdata));
	rmps_top u_rmps_top (.I_CLK(clk), .I_RST(rst), .I_CHIP_EN(chip_en),
		.I_WR_EN(wr_en), .I_RD_EN(rd_en), .I_ADDR(addr), .I_WDATA(wdata),
		.O_RDATA(rdata), .O_RDATA_VALID(rdv), .O_STANDBY(stby),
		.O_DIRECT_ACTIVE(dact), .O_DIRECT_MODE1(dm1), .O_TX_ENABLE(txe),
		.O_RX_ENABLE(rxe), .O_TX_OSC_ENABLE(osc), .O_TX_HALF_POWER(half),
		.O_AUX_INPUT_SEL(aux), .O_SUPPLY_5V(s5), .O_NO_RX_CRC(ncrc),
		.O_PROTO_FAMILY(fam), .O_RX_RATE_SEL(rate), .O_CODING_256(cod),
		.O_DOUBLE_SUBCARRIER(dbl), .O_PROTO_RESERVED(res),
		.O_OPTION_RELOAD(rel));
	task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic rchk(input logic [4:0] a, input logic [7:0] e);
		u_rmps_host.rd(a, rv, v);
		chk("read valid", 1, v);
		chk("read data", e, rv);
	endtask
	task automatic give_verdict;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Family, rate, coding, double, reserved for a protocol code
	function automatic logic [7:0] exp_ps(input logic [4:0] c);
		logic [2:0] f;
		logic [1:0] r;
		f = c < 16 ? c[4:2] : (c == 26 || c == 27) ? 3'h4 : 3'h7;
		r = c < 8 ? {1'b0, c[1]} : c < 16 ? c[1:0] :
			c == 26 ? 2'h1 : c == 27 ? 2'h2 : 2'h0;
		return {f, r, c < 8 && c[0], f == 3'h1, f == 3'h7};
	endfunction
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		#1 rst = 0;
		rchk(0, 8'h01);
		rchk(1, 8'h02);
		chk("proto", exp_ps(2), {fam, rate, cod, dbl, res});
		rchk(5'h05, 8'h00);
		// Every chip mode value; variant still 0 from reset
		for (int i = 0; i < 256; i++) begin
			d = i;
			u_rmps_host.wr(0, d);
			chk("half power", d[4], half);
			chk("aux input", d[3], aux);
			chk("rx enable", d[1] | d[5], rxe);
			chk("osc enable", d[1] | d[5], osc);
			chk("tx enable", d[5], txe);
			chk("supply 5v", d[0], s5);
			chk("standby", d[7], stby);
			chk("direct", d[6], dact);
			chk("mode1 idle", 0, dm1);
			rchk(0, d & 8'hfb);
		end
		for (int i = 0; i < 32; i++) begin
			d = {i[0], i[1], 1'b0, i[4:0]};
			u_rmps_host.wr(1, d);
			chk("reload", 1, rel);
			ep = exp_ps(d[4:0]);
			chk("family", ep[7:5], fam);
			chk("rate", ep[4:3], rate);
			chk("coding", ep[2], cod);
			chk("double", ep[1], dbl);
			chk("reserved", ep[0], res);
			chk("no crc", d[7], ncrc);
			u_rmps_host.wr(0, 8'h40);
			chk("variant", d[6], dm1);
			chk("reload", 0, rel);
			rchk(1, d);
		end
		// Chip enable low must act as reset
		chip_en = 0;
		@(posedge clk);
		#1 chip_en = 1;
		chk("proto", exp_ps(2), {fam, rate, cod, dbl, res});
		chk("mode1 reset", 0, dm1);
		rchk(1, 8'h02);
		rchk(0, 8'h01);
		give_verdict;
	end
	// Run is about 1250 cycles; limit leaves fourfold margin
	initial begin
		#(100 * 5000);
		miscompares++;
		give_verdict;
	end
endmodule
